// >>> rtl/fdstr_pkg.sv
package fdstr_pkg;

	// register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DENOM_LO = 8'h04;
	localparam logic [7:0] OFS_DENOM_HI = 8'h08;
	localparam logic [7:0] OFS_NUMER_LO = 8'h0c;
	localparam logic [7:0] OFS_NUMER_HI = 8'h10;
	localparam logic [7:0] OFS_SPUR_STAGE = 8'h14;
	localparam logic [7:0] OFS_SPUR_APPLIED = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	localparam logic [7:0] OFS_DENOM_EFF = 8'h20;
	localparam logic [7:0] OFS_NUMER_EFF = 8'h24;

	// field widths
	localparam int LO_W = 12;
	localparam int HI_W = 10;
	localparam int FULL_W = 22;
	localparam int WORD_W = 24;

	// control register fields
	localparam int CTRL_WIDTH_SEL_BIT = 0;

	// status register fields
	localparam int STAT_REJECT_BIT = 0;
	localparam int STAT_LOW_DENOM_BIT = 1;
	localparam int STAT_ZERO_NUMER_BIT = 2;
	localparam int STAT_LANES_LSB = 4;

	// spur-tuning word layout
	localparam int SPUR_ADDR_LSB = 0;
	localparam int SPUR_ADDR_MSB = 3;
	localparam int SPUR_PUMP_LSB = 5;
	localparam int SPUR_PUMP_MSB = 7;
	localparam int SPUR_BOOST_LSB = 10;
	localparam int SPUR_BOOST_MSB = 11;
	localparam int SPUR_DITHER_CONTROL_LSB = 18;
	localparam int SPUR_DITHER_CONTROL_MSB = 19;
	localparam logic [3:0] SPUR_ADDR_CODE = 4'hf;
	localparam logic [23:0] SPUR_FIELD_MASK = 24'h0c0cef;

	// field codes
	localparam logic [2:0] PUMP_MIN = 3'h2;
	localparam logic [2:0] PUMP_MAX = 3'h3;
	localparam logic [2:0] PUMP_NOM = 3'h7;
	localparam logic [1:0] BOOST_DOUBLE = 2'h2;
	localparam logic [1:0] BOOST_OFF = 2'h3;
	localparam logic [1:0] DITHER_CONTROL_ON = 2'h0;
	localparam logic [1:0] DITHER_CONTROL_OFF = 2'h3;

	// values after reset
	localparam logic [23:0] SPUR_RESET = 24'h0c0cef;
	localparam logic [11:0] LO_RESET = 12'h000;
	localparam logic [9:0] HI_RESET = 10'h000;
	localparam logic CTRL_WIDTH_RESET = 1'b0;

	// dithering advisory threshold on the denominator
	localparam logic [21:0] DITHER_CONTROL_MIN_DENOM = 22'h0003e8;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// true when a complete spur word has legal address, zero bits and codes
	function automatic logic spur_word_ok(input logic [23:0] w);
		logic [2:0] pm;
		logic [1:0] bc;
		logic [1:0] dc;
		pm = w[SPUR_PUMP_MSB:SPUR_PUMP_LSB];
		bc = w[SPUR_BOOST_MSB:SPUR_BOOST_LSB];
		dc = w[SPUR_DITHER_CONTROL_MSB:SPUR_DITHER_CONTROL_LSB];
		spur_word_ok = (w[SPUR_ADDR_MSB:SPUR_ADDR_LSB] == SPUR_ADDR_CODE)
			&& ((w & ~SPUR_FIELD_MASK) == 24'h000000)
			&& (pm == PUMP_MIN || pm == PUMP_MAX || pm == PUMP_NOM)
			&& (bc == BOOST_DOUBLE || bc == BOOST_OFF)
			&& (dc == DITHER_CONTROL_ON || dc == DITHER_CONTROL_OFF);
	endfunction

	// joins upper and lower parts according to the width select
	function automatic logic [21:0] join_value(input logic sel, input logic [9:0] hi,
		input logic [11:0] lo);
		join_value = sel ? {hi, lo} : {10'h000, lo};
	endfunction

endpackage

// >>> rtl/fdstr_word_latch.sv
`timescale 1ns/1ps
module fdstr_word_latch
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// staging write from the bus
	input wire logic wr_en,
	input wire logic [23:0] wr_data,
	input wire logic [2:0] wr_lanes,
	// applied settings, staging lane mask and reject pulse
	output logic [23:0] applied_word,
	output logic [2:0] pump_mode,
	output logic boost_double,
	output logic dither_en,
	output logic [2:0] lanes_seen,
	output logic reject_pulse
);

	logic [23:0] stage_ff;
	logic [2:0] lanes_ff;
	logic [23:0] applied_ff;
	logic reject_ff;
	logic [23:0] nxt_stage;
	logic [2:0] nxt_lanes;

	// merge the written byte lanes into the staged word
	always_comb
	begin
		nxt_stage = stage_ff;
		for (int i = 0; i < 3; i++)
			if (wr_lanes[i])
				nxt_stage[i*8 +: 8] = wr_data[i*8 +: 8];
		nxt_lanes = lanes_ff | wr_lanes;
	end

	// staging holds partial words; lane mask resets once the word is complete
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage_ff <= 24'h000000;
			lanes_ff <= 3'h0;
		end
		else if (wr_en)
		begin
			stage_ff <= nxt_stage;
			lanes_ff <= (nxt_lanes == 3'h7) ? 3'h0 : nxt_lanes;
		end
	end

	// only a complete, legal word replaces the operating settings
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			applied_ff <= fdstr_pkg::SPUR_RESET;
		else if (wr_en && nxt_lanes == 3'h7 && fdstr_pkg::spur_word_ok(nxt_stage))
			applied_ff <= nxt_stage;
	end

	// one-cycle pulse when a complete word is refused
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			reject_ff <= 1'b0;
		else
			reject_ff <= wr_en && nxt_lanes == 3'h7 && !fdstr_pkg::spur_word_ok(nxt_stage);
	end

	// decoded field views of the applied word
	assign applied_word = applied_ff;
	assign pump_mode = applied_ff[fdstr_pkg::SPUR_PUMP_MSB:fdstr_pkg::SPUR_PUMP_LSB];
	assign boost_double = applied_ff[fdstr_pkg::SPUR_BOOST_MSB:fdstr_pkg::SPUR_BOOST_LSB]
		== fdstr_pkg::BOOST_DOUBLE;
	assign dither_en = applied_ff[fdstr_pkg::SPUR_DITHER_CONTROL_MSB:fdstr_pkg::SPUR_DITHER_CONTROL_LSB]
		== fdstr_pkg::DITHER_CONTROL_ON;
	assign lanes_seen = lanes_ff;
	assign reject_pulse = reject_ff;

endmodule

// >>> rtl/fdstr_top.sv
`timescale 1ns/1ps
// How it works
// - width select 0 uses only the lower 12 denominator bits, upper ignored.
// - width select 1 joins upper 10 bits above lower 12 into 22 bits.
// - spur word has address ones in 3:0, fields placed, all other bits zero.
// - pump mode codes 2, 3, 7 legal; pump current itself never changes.
// - boost code 2 doubles fast-lock current, 3 disables; 0 and 1 illegal.
// - dither code 0 enables, 3 disables; codes 1 and 2 reserved.
// - width select also switches numerator between 12 and 22 bits.
module fdstr_top
#(
	parameter int ADDR_W = 8
)
(
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] AWADDR,
	input wire logic [2:0] AWPROT,
	input wire logic AWVALID,
	output logic AWREADY,
	// axi4-lite write data
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	// axi4-lite write response
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] ARADDR,
	input wire logic [2:0] ARPROT,
	input wire logic ARVALID,
	output logic ARREADY,
	// axi4-lite read data
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// operating settings
	output logic DENOM_22BIT,
	output logic [21:0] DENOM_VALUE,
	output logic [21:0] NUMER_VALUE,
	output logic [2:0] PUMP_USER_MODE,
	output logic BOOST_DOUBLE,
	output logic DITHER_EN
);

	logic awready_ff;
	logic wready_ff;
	logic aw_held_ff;
	logic w_held_ff;
	logic [7:0] waddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arready_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic denom_width_select_ff;
	logic [11:0] denom_lower_bits_ff;
	logic [9:0] denom_upper_bits_ff;
	logic [11:0] numer_lower_bits_ff;
	logic [9:0] numer_upper_bits_ff;
	logic reject_sticky_ff;
	logic [21:0] denom_out_ff;
	logic [21:0] numer_out_ff;
	logic width_out_ff;
	logic [2:0] pump_out_ff;
	logic boost_out_ff;
	logic dither_out_ff;
	logic wr_go;
	logic [7:0] rd_addr;
	logic [31:0] nxt_rdata;
	logic nxt_rd_hit;
	logic wr_hit;
	logic spur_wr;
	logic [23:0] applied_word;
	logic [2:0] pump_mode;
	logic boost_double;
	logic dither_en;
	logic [2:0] lanes_seen;
	logic reject_pulse;
	logic [21:0] denom_join;
	logic [21:0] numer_join;
	logic low_denom_warn;
	logic zero_numer_warn;

	// a write is carried out once address and data are both held
	assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
	assign spur_wr = wr_go && waddr_ff[7:2] == fdstr_pkg::OFS_SPUR_STAGE[7:2];
	assign rd_addr = 8'(ARADDR);

	// write-side decode: which offsets accept a write
	always_comb
	begin
		case ({waddr_ff[7:2], 2'b00})
			fdstr_pkg::OFS_CTRL,
			fdstr_pkg::OFS_DENOM_LO,
			fdstr_pkg::OFS_DENOM_HI,
			fdstr_pkg::OFS_NUMER_LO,
			fdstr_pkg::OFS_NUMER_HI,
			fdstr_pkg::OFS_SPUR_STAGE,
			fdstr_pkg::OFS_STATUS: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// write address channel: accept one, hold until the response is taken
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			awready_ff <= 1'b1;
			aw_held_ff <= 1'b0;
			waddr_ff <= 8'h00;
		end
		else if (AWVALID && awready_ff)
		begin
			awready_ff <= 1'b0;
			aw_held_ff <= 1'b1;
			waddr_ff <= 8'(AWADDR);
		end
		else if (bvalid_ff && BREADY)
		begin
			awready_ff <= 1'b1;
			aw_held_ff <= 1'b0;
		end
	end

	// write data channel: same discipline as the address
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			wready_ff <= 1'b1;
			w_held_ff <= 1'b0;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
		end
		else if (WVALID && wready_ff)
		begin
			wready_ff <= 1'b0;
			w_held_ff <= 1'b1;
			wdata_ff <= WDATA;
			wstrb_ff <= WSTRB;
		end
		else if (bvalid_ff && BREADY)
		begin
			wready_ff <= 1'b1;
			w_held_ff <= 1'b0;
		end
	end

	// write response, error for an unmapped or read-only offset
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff <= fdstr_pkg::RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_hit ? fdstr_pkg::RESP_OKAY : fdstr_pkg::RESP_SLVERR;
		end
		else if (bvalid_ff && BREADY)
			bvalid_ff <= 1'b0;
	end

	// width select bit
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			denom_width_select_ff <= fdstr_pkg::CTRL_WIDTH_RESET;
		else if (wr_go && waddr_ff[7:2] == fdstr_pkg::OFS_CTRL[7:2] && wstrb_ff[0])
			denom_width_select_ff <= wdata_ff[fdstr_pkg::CTRL_WIDTH_SEL_BIT];
	end

	// denominator parts, upper part stored even while it is ignored
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			denom_lower_bits_ff <= fdstr_pkg::LO_RESET;
			denom_upper_bits_ff <= fdstr_pkg::HI_RESET;
		end
		else if (wr_go)
		begin
			if (waddr_ff[7:2] == fdstr_pkg::OFS_DENOM_LO[7:2])
				denom_lower_bits_ff <= merge12(denom_lower_bits_ff, wdata_ff, wstrb_ff);
			if (waddr_ff[7:2] == fdstr_pkg::OFS_DENOM_HI[7:2])
				denom_upper_bits_ff <= merge10(denom_upper_bits_ff, wdata_ff, wstrb_ff);
		end
	end

	// numerator parts, handled like the denominator
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			numer_lower_bits_ff <= fdstr_pkg::LO_RESET;
			numer_upper_bits_ff <= fdstr_pkg::HI_RESET;
		end
		else if (wr_go)
		begin
			if (waddr_ff[7:2] == fdstr_pkg::OFS_NUMER_LO[7:2])
				numer_lower_bits_ff <= merge12(numer_lower_bits_ff, wdata_ff, wstrb_ff);
			if (waddr_ff[7:2] == fdstr_pkg::OFS_NUMER_HI[7:2])
				numer_upper_bits_ff <= merge10(numer_upper_bits_ff, wdata_ff, wstrb_ff);
		end
	end

	// byte-lane merge into a 12-bit field
	function automatic logic [11:0] merge12(input logic [11:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge12 = {s[1] ? d[11:8] : old[11:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// byte-lane merge into a 10-bit field
	function automatic logic [9:0] merge10(input logic [9:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge10 = {s[1] ? d[9:8] : old[9:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// spur word staging and apply
	fdstr_word_latch u_word_latch
	(
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.wr_en(spur_wr),
		.wr_data(wdata_ff[23:0]),
		.wr_lanes(wstrb_ff[2:0]),
		.applied_word(applied_word),
		.pump_mode(pump_mode),
		.boost_double(boost_double),
		.dither_en(dither_en),
		.lanes_seen(lanes_seen),
		.reject_pulse(reject_pulse)
	);

	// effective values: upper part ignored in 12-bit form
	assign denom_join = fdstr_pkg::join_value(denom_width_select_ff, denom_upper_bits_ff,
		denom_lower_bits_ff);
	assign numer_join = fdstr_pkg::join_value(denom_width_select_ff, numer_upper_bits_ff,
		numer_lower_bits_ff);

	// advisory flags for host-side dithering guidance
	assign low_denom_warn = dither_en && denom_join < fdstr_pkg::DITHER_CONTROL_MIN_DENOM;
	assign zero_numer_warn = dither_en && numer_join == 22'h000000;

	// sticky reject flag, write one to clear; a new reject wins
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			reject_sticky_ff <= 1'b0;
		else if (reject_pulse)
			reject_sticky_ff <= 1'b1;
		else if (wr_go && waddr_ff[7:2] == fdstr_pkg::OFS_STATUS[7:2] && wstrb_ff[0]
			&& wdata_ff[fdstr_pkg::STAT_REJECT_BIT])
			reject_sticky_ff <= 1'b0;
	end

	// read decode
	always_comb
	begin
		nxt_rdata = 32'h00000000;
		nxt_rd_hit = 1'b1;
		case ({rd_addr[7:2], 2'b00})
			fdstr_pkg::OFS_CTRL: nxt_rdata[0] = denom_width_select_ff;
			fdstr_pkg::OFS_DENOM_LO: nxt_rdata[11:0] = denom_lower_bits_ff;
			fdstr_pkg::OFS_DENOM_HI: nxt_rdata[9:0] = denom_upper_bits_ff;
			fdstr_pkg::OFS_NUMER_LO: nxt_rdata[11:0] = numer_lower_bits_ff;
			fdstr_pkg::OFS_NUMER_HI: nxt_rdata[9:0] = numer_upper_bits_ff;
			fdstr_pkg::OFS_SPUR_STAGE: nxt_rdata = 32'h00000000; // write-only
			fdstr_pkg::OFS_SPUR_APPLIED: nxt_rdata[23:0] = applied_word;
			fdstr_pkg::OFS_STATUS:
			begin
				nxt_rdata[fdstr_pkg::STAT_REJECT_BIT] = reject_sticky_ff;
				nxt_rdata[fdstr_pkg::STAT_LOW_DENOM_BIT] = low_denom_warn;
				nxt_rdata[fdstr_pkg::STAT_ZERO_NUMER_BIT] = zero_numer_warn;
				nxt_rdata[fdstr_pkg::STAT_LANES_LSB +: 3] = lanes_seen;
			end
			fdstr_pkg::OFS_DENOM_EFF: nxt_rdata[21:0] = denom_join;
			fdstr_pkg::OFS_NUMER_EFF: nxt_rdata[21:0] = numer_join;
			default: nxt_rd_hit = 1'b0;
		endcase
	end

	// read channel: one outstanding read, data one cycle after the address
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= fdstr_pkg::RESP_OKAY;
		end
		else if (ARVALID && arready_ff)
		begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rd_hit ? fdstr_pkg::RESP_OKAY : fdstr_pkg::RESP_SLVERR;
		end
		else if (rvalid_ff && RREADY)
		begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
		end
	end

	// registered operating outputs
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			width_out_ff <= fdstr_pkg::CTRL_WIDTH_RESET;
			denom_out_ff <= 22'h000000;
			numer_out_ff <= 22'h000000;
			pump_out_ff <= fdstr_pkg::PUMP_NOM;
			boost_out_ff <= 1'b0;
			dither_out_ff <= 1'b0;
		end
		else
		begin
			width_out_ff <= denom_width_select_ff;
			denom_out_ff <= denom_join;
			numer_out_ff <= numer_join;
			pump_out_ff <= pump_mode;
			boost_out_ff <= boost_double;
			dither_out_ff <= dither_en;
		end
	end

	// port hookup
	assign AWREADY = awready_ff;
	assign WREADY = wready_ff;
	assign BVALID = bvalid_ff;
	assign BRESP = bresp_ff;
	assign ARREADY = arready_ff;
	assign RVALID = rvalid_ff;
	assign RDATA = rdata_ff;
	assign RRESP = rresp_ff;
	assign DENOM_22BIT = width_out_ff;
	assign DENOM_VALUE = denom_out_ff;
	assign NUMER_VALUE = numer_out_ff;
	assign PUMP_USER_MODE = pump_out_ff;
	assign BOOST_DOUBLE = boost_out_ff;
	assign DITHER_EN = dither_out_ff;

endmodule

// >>> dv/fdstr_chk.sv
`timescale 1ns/1ps
// protocol and settings checks on the top ports
module fdstr_chk
(
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// bus handshakes
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic [1:0] BRESP,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic RVALID,
	input wire logic RREADY,
	// operating settings
	input wire logic DENOM_22BIT,
	input wire logic [21:0] DENOM_VALUE,
	input wire logic [21:0] NUMER_VALUE,
	input wire logic [2:0] PUMP_USER_MODE,
	input wire logic BOOST_DOUBLE,
	input wire logic DITHER_EN
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	// narrow mode keeps the upper ten bits out of both values
	denom_narrow_a: assert property (!DENOM_22BIT |-> DENOM_VALUE[21:12] == 10'h000)
		else $error("denominator upper bits used in narrow mode");
	numer_narrow_a: assert property (!DENOM_22BIT |-> NUMER_VALUE[21:12] == 10'h000)
		else $error("numerator upper bits used in narrow mode");
	pump_code_a: assert property (PUMP_USER_MODE inside {3'h2, 3'h3, 3'h7})
		else $error("reserved pump mode applied");
	// settings move only as the tail of a completed write
	apply_after_write_a: assert property ($changed({PUMP_USER_MODE, BOOST_DOUBLE, DITHER_EN,
		DENOM_VALUE, NUMER_VALUE}) |-> $past(BVALID) || BVALID)
		else $error("settings changed without a completed write");
	// bus timing as handed over
	wr_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
		else $error("write response late");
	aw_busy_a: assert property (AWVALID && AWREADY |=> !AWREADY [*2])
		else $error("write address ready too early");
	bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped");
	rd_answer_a: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
		else $error("read answer not one cycle later");
	rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read data dropped");

	// main scenarios
	cover property ($changed(PUMP_USER_MODE));
	cover property (BVALID && !BREADY);
	cover property (DENOM_22BIT && DENOM_VALUE[21:12] != 10'h000);
	cover property (BVALID && BRESP == fdstr_pkg::RESP_SLVERR);
endmodule

// >>> dv/fdstr_host.sv
`timescale 1ns/1ps
// bus master standing in for the host that loads the control words
module fdstr_host
(
	// clock
	input wire logic clk,
	// write channels
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// read channels
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready,
	// raised when a wait runs out
	output logic timed_out
);
	int lag = 0;
	// idle bus at time zero
	initial
	begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready, timed_out} = '0;
	end
	// one write, payload released and scrambled once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		{awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, s, 2'b11, lag == 0};
		do
		begin
			@(posedge clk);
			n++;
			if (awvalid && awready)
				{awvalid, awaddr} <= {1'b0, ~a};
			if (wvalid && wready)
				{wvalid, wdata} <= {1'b0, ~d};
			if (n >= lag && !(bvalid && bready))
				bready <= 1'b1;
		end
		while (!(bvalid && bready) && n < 200);
		r = bresp;
		bready <= 1'b0;
		timed_out <= n >= 200;
	endtask
	// one read, ready possibly held back for a few cycles
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		{araddr, arvalid, rready} <= {a, 1'b1, lag == 0};
		do
		begin
			@(posedge clk);
			n++;
			if (arvalid && arready)
				{arvalid, araddr} <= {1'b0, ~a};
			if (n >= lag && !(rvalid && rready))
				rready <= 1'b1;
		end
		while (!(rvalid && rready) && n < 200);
		{d, r} = {rdata, rresp};
		rready <= 1'b0;
		timed_out <= n >= 200;
	endtask
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic sys_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, timed_out, denom_22bit, boost_double, dither_en;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic [21:0] denom_value, numer_value;
	logic [2:0] pump_user_mode;
	int error_cnt = 0;
	int n_compared = 0;
	int m_sel, m_dlo, m_dhi, m_nlo, m_nhi, m_spur;

	fdstr_top u_fdstr_top (.SYS_CLK(sys_clk), .RST_N(rst_n), .AWADDR(awaddr), .AWPROT(3'h0),
		.AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
		.WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
		.ARPROT(3'h0), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
		.RVALID(rvalid), .RREADY(rready), .DENOM_22BIT(denom_22bit), .DENOM_VALUE(denom_value),
		.NUMER_VALUE(numer_value), .PUMP_USER_MODE(pump_user_mode),
		.BOOST_DOUBLE(boost_double), .DITHER_EN(dither_en));
	fdstr_host u_fdstr_host (.clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.timed_out(timed_out));

	// 25 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// model of the spur word check: address ones, zero filler, legal codes
	function automatic bit spur_legal(int w);
		int p, b, t;
		p = (w >> 5) & 7;
		b = (w >> 10) & 3;
		t = (w >> 18) & 3;
		return (w & 32'h0000000f) == 15 && (w & 32'hfff3f310) == 0
			&& (p == 2 || p == 3 || p == 7) && b >= 2 && (t == 0 || t == 3);
	endfunction
	// load width select and both fractions from the model
	task automatic load();
		u_fdstr_host.wr(8'h00, m_sel, 4'hf, resp);
		u_fdstr_host.wr(8'h04, m_dlo, 4'hf, resp);
		u_fdstr_host.wr(8'h08, m_dhi, 4'hf, resp);
		u_fdstr_host.wr(8'h0c, m_nlo, 4'hf, resp);
		u_fdstr_host.wr(8'h10, m_nhi, 4'hf, resp);
	endtask
	// compare outputs and readback with the model
	task automatic check_all();
		int d, n;
		d = m_sel ? m_dhi * 4096 + m_dlo : m_dlo;
		n = m_sel ? m_nhi * 4096 + m_nlo : m_nlo;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("denom_22bit", {31'h0, denom_22bit}, m_sel);
		chk("denom_value", {10'h000, denom_value}, d);
		chk("numer_value", {10'h000, numer_value}, n);
		chk("pump_user_mode", {29'h0, pump_user_mode}, (m_spur >> 5) & 7);
		chk("boost_double", {31'h0, boost_double}, ((m_spur >> 10) & 3) == 2);
		chk("dither_en", {31'h0, dither_en}, ((m_spur >> 18) & 3) == 0);
		u_fdstr_host.rd(8'h20, rv, resp);
		chk("denom readback", rv, d);
		u_fdstr_host.rd(8'h24, rv, resp);
		chk("numer readback", rv, n);
		u_fdstr_host.rd(8'h18, rv, resp);
		chk("applied word", rv, m_spur);
	endtask
	// hang guard
	initial
	begin
		repeat (100000) @(posedge sys_clk);
		error_cnt++;
		end_of_test();
	end
	always @(posedge timed_out)
	begin
		error_cnt++;
		end_of_test();
	end
	// main sequence
	initial
	begin
		int d, n, w;
		int dtab[4];
		void'($urandom(32'h3caa2e60));
		dtab = '{1, 4095, 4096, 4194303};
		rst_n = 1'b0;
		{m_sel, m_dlo, m_dhi, m_nlo, m_nhi} = '0;
		m_spur = 32'h000c0cef;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		check_all();
		u_fdstr_host.rd(8'h14, rv, resp);
		chk("spur readback", rv, 0);
		// both widths, boundary denominators first, upper bits split by the main sequence
		for (int i = 0; i < 30; i++)
		begin
			d = i < 8 ? dtab[i / 2] : $urandom_range(4194303, 0);
			n = $urandom_range(4194303, 0);
			m_sel = i % 2;
			{m_dlo, m_dhi, m_nlo, m_nhi} = {d % 4096, d / 4096, n % 4096, n / 4096};
			load();
			check_all();
		end
		// dithering only with a large denominator and a nonzero numerator
		{m_sel, m_dlo, m_dhi, m_nlo, m_nhi} = {32'h1, 32'h7d0, 32'h0, 32'h5, 32'h0};
		load();
		// every code of every spur field, with slow responses mixed in
		for (int i = 0; i < 128; i++)
		begin
			w = 15 | (i & 7) << 5 | ((i >> 3) & 3) << 10 | (i >> 5) << 18;
			u_fdstr_host.lag = i % 3;
			u_fdstr_host.wr(8'h14, w, 4'hf, resp);
			m_spur = spur_legal(w) ? w : m_spur;
			check_all();
		end
		// bad address code, then a filler bit set: both rejected whole
		u_fdstr_host.wr(8'h14, 32'h000c0cee, 4'hf, resp);
		u_fdstr_host.wr(8'h14, 32'h001c0cef, 4'hf, resp);
		check_all();
		u_fdstr_host.rd(8'h1c, rv, resp);
		chk("reject flag", rv[0], 1);
		u_fdstr_host.wr(8'h1c, 32'h1, 4'hf, resp);
		u_fdstr_host.rd(8'h1c, rv, resp);
		chk("reject cleared", rv[0], 0);
		// one lane alone changes nothing until the word is complete
		u_fdstr_host.wr(8'h14, 32'h0000084f, 4'h1, resp);
		check_all();
		u_fdstr_host.wr(8'h14, 32'h0000084f, 4'h6, resp);
		m_spur = 32'h0000084f;
		check_all();
		// unmapped and read-only places answer with an error and leave settings
		u_fdstr_host.wr(8'h30, 32'h1, 4'hf, resp);
		chk("unmapped write", resp, 2);
		u_fdstr_host.rd(8'h30, rv, resp);
		chk("unmapped read resp", {30'h0, resp}, 32'h2);
		chk("unmapped read data", rv, 32'h0);
		u_fdstr_host.wr(8'h18, 32'h0, 4'hf, resp);
		chk("read-only write", resp, 2);
		check_all();
		end_of_test();
	end
endmodule

bind fdstr_top fdstr_chk u_fdstr_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .AWVALID(AWVALID),
	.AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
	.BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID),
	.RREADY(RREADY), .DENOM_22BIT(DENOM_22BIT), .DENOM_VALUE(DENOM_VALUE),
	.NUMER_VALUE(NUMER_VALUE), .PUMP_USER_MODE(PUMP_USER_MODE), .BOOST_DOUBLE(BOOST_DOUBLE),
	.DITHER_EN(DITHER_EN));
